/* core/boot_image_validator_defs.svh */
// constants of the boot image validator: offsets, fields, counts
`ifndef BOOT_IMAGE_VALIDATOR_DEFS_SVH
`define BOOT_IMAGE_VALIDATOR_DEFS_SVH

// address map
`define BIV_RESET_VECTOR 32'h0000_0000
`define BIV_ROM_ALIAS_BASE 32'h0010_0000
`define BIV_REGION_MASK 32'hFFF0_0000

// image header: eight vector words, the sixth one is the descriptor
`define BIV_NUM_VECTORS 4'h8
`define BIV_HEADER_BYTES 32
`define BIV_DESC_INDEX 3'h5

// vector word fields
`define BIV_COND_MSB 31
`define BIV_COND_LSB 28
`define BIV_COND_ALWAYS 4'hE
`define BIV_BRANCH_MSB 27
`define BIV_BRANCH_LSB 24
`define BIV_BRANCH_CODE 4'hA
`define BIV_LDR_CLASS_MSB 27
`define BIV_LDR_CLASS_LSB 26
`define BIV_LDR_CLASS 2'h1
`define BIV_LDR_P_BIT 24
`define BIV_LDR_U_BIT 23
`define BIV_LDR_L_BIT 20
`define BIV_RN_MSB 19
`define BIV_RN_LSB 16
`define BIV_RD_MSB 15
`define BIV_RD_LSB 12
`define BIV_PC_REG 4'hF

// descriptor fields
`define BIV_BLOCKS_MSB 7
`define BIV_BLOCKS_LSB 0
`define BIV_PAGES_EXP_MSB 16
`define BIV_PAGES_EXP_LSB 13
`define BIV_PAGE_SIZE_MSB 31
`define BIV_PAGE_SIZE_LSB 17

// copy geometry: a block is 512 bytes, i.e. 128 words
`define BIV_BLOCK_BYTES 512
`define BIV_BLOCK_WORDS_LOG2 7

// rom descriptor structure: identity and routine entry points
`define BIV_ROM_DESC_ADDR 32'h0010_0040
// chip identity value is arbitrary, chosen for this block only
`define BIV_CHIP_ID 32'h0000_0A5A
`define BIV_ENTRY_READ_NVM 32'h0010_0100
`define BIV_ENTRY_COPY 32'h0010_0200
`define BIV_ENTRY_UPLOAD 32'h0010_0300

`endif

/* core/boot_image_validator_pkg.sv */
// types of the boot image validator
package boot_image_validator_pkg;

  typedef enum logic [1:0] {
    SRC_SPI_FLASH,
    SRC_EEPROM,
    SRC_PARALLEL,
    SRC_NONE
  } nvm_src_t;

  typedef enum {
    ST_STRAP,
    ST_EXT_BOOT,
    ST_HDR_REQ,
    ST_HDR_WAIT,
    ST_NEXT_SRC,
    ST_COPY_REQ,
    ST_COPY_WAIT,
    ST_REMAP,
    ST_RUN,
    ST_UPLOAD
  } boot_state_t;

  typedef logic [31:0] word_t;

endpackage

/* core/vector_check_if.sv */
// carrier between the sequencer and the vector checker
`timescale 1ns/1ps
interface vector_check_if;
  logic [31:0] word;
  logic is_desc;
  logic word_ok;
  logic [7:0] blocks;
  logic [3:0] pages_exp;
  logic [14:0] page_size;

  modport seq (output word, output is_desc, input word_ok, input blocks, input pages_exp,
               input page_size);
  modport chk (input word, input is_desc, output word_ok, output blocks, output pages_exp,
               output page_size);
endinterface

/* core/vector_checker.sv */
// vector word checker and descriptor field decoder
`timescale 1ns/1ps
`include "boot_image_validator_defs.svh"

module vector_checker (
  vector_check_if.chk vc
);

  logic cond_ok;
  logic is_branch;
  logic is_pc_load;

  // top nibble must be the always condition
  assign cond_ok = vc.word[`BIV_COND_MSB:`BIV_COND_LSB] == `BIV_COND_ALWAYS;
  // branch: class 1010, offset free
  assign is_branch = vc.word[`BIV_BRANCH_MSB:`BIV_BRANCH_LSB] == `BIV_BRANCH_CODE;
  // pc relative load into pc; write-back and up/down left free
  assign is_pc_load = (vc.word[`BIV_LDR_CLASS_MSB:`BIV_LDR_CLASS_LSB] == `BIV_LDR_CLASS)
                    && vc.word[`BIV_LDR_P_BIT] && vc.word[`BIV_LDR_L_BIT]
                    && (vc.word[`BIV_RN_MSB:`BIV_RN_LSB] == `BIV_PC_REG)
                    && (vc.word[`BIV_RD_MSB:`BIV_RD_LSB] == `BIV_PC_REG);

  // descriptor word is exempt from the opcode test
  assign vc.word_ok = vc.is_desc || (cond_ok && (is_branch || is_pc_load));

  // reserved bits 12..8 are never looked at
  assign vc.blocks = vc.word[`BIV_BLOCKS_MSB:`BIV_BLOCKS_LSB];
  assign vc.pages_exp = vc.word[`BIV_PAGES_EXP_MSB:`BIV_PAGES_EXP_LSB];
  assign vc.page_size = vc.word[`BIV_PAGE_SIZE_MSB:`BIV_PAGE_SIZE_LSB];

endmodule // vector_checker

/* core/boot_image_validator.sv */
// boot image validator: probes memories, checks vectors, copies image, remaps
`timescale 1ns/1ps
`include "boot_image_validator_defs.svh"

// Operation
// - with boot-mode-select high at reset, boot starts from the reset vector at zero
// - before remap rom answers both at zero and at the alias base
// - search memories, copy valid image to sram, remap, then branch to zero
// - validity judged only from the first 32 bytes, eight vector words
// - sixth vector word is exempt and holds the download descriptor
// - each checked word needs the always condition code in bits 31..28
// - pc load needs base and destination fields 15, load and pre-index set
// - pc load accepts either value of the up/down bit
// - descriptor bits 7..0 give the count of 512-byte blocks to copy
// - descriptor bits 16..13 give exponent n, flash page count is two to n
// - descriptor bits 31..17 give the serial flash page size in bytes
// - for eeprom or parallel memory only the block count is used
// - copy length always comes from the descriptor word
// - with no valid image anywhere, fall back to serial or usb upload
// - rom holds a fixed descriptor with chip identity and routine entry points
// - probe order: flash on chip select zero, eeprom, then parallel memory
module boot_image_validator (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // strap and product options
  input wire logic boot_mode_select,
  input wire logic has_ext_bus,
  // non-volatile memory word read port
  output logic nvm_req,
  output boot_image_validator_pkg::nvm_src_t nvm_src,
  output logic [16:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic nvm_nak,
  input wire logic [31:0] nvm_rdata,
  // internal sram write port
  output logic sram_we,
  output logic [14:0] sram_waddr,
  output logic [31:0] sram_wdata,
  // processor address decode
  input wire logic [31:0] cpu_addr,
  output logic rom_sel,
  output logic sram_sel,
  // rom descriptor structure read
  input wire logic [1:0] rom_desc_idx,
  output logic [31:0] rom_desc_data,
  // boot outcome
  output logic remap,
  output logic cpu_start,
  output logic [31:0] cpu_start_addr,
  output logic ext_boot,
  output logic upload_mode,
  output boot_image_validator_pkg::nvm_src_t boot_src,
  output logic [7:0] image_blocks,
  output logic [3:0] flash_pages_exp,
  output logic [15:0] flash_pages,
  output logic [14:0] flash_page_size
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  boot_image_validator_pkg::boot_state_t state_r;
  boot_image_validator_pkg::nvm_src_t src_r;
  logic [2:0] hdr_idx_r;
  logic hdr_ok_r;
  logic [7:0] blocks_r;
  logic [3:0] pages_exp_r;
  logic [14:0] page_size_r;
  logic [14:0] copy_idx_r;
  logic [14:0] copy_words;
  logic copy_last;
  logic hdr_last;

  vector_check_if vc ();

  vector_checker u_checker (
    .vc(vc.chk)
  );

  assign vc.word = nvm_rdata;
  assign vc.is_desc = hdr_idx_r == `BIV_DESC_INDEX;

  // copy length derived solely from the descriptor
  assign copy_words = {blocks_r, {`BIV_BLOCK_WORDS_LOG2{1'b0}}};
  assign copy_last = copy_idx_r == (copy_words - 15'h0001);
  assign hdr_last = hdr_idx_r == 3'(`BIV_NUM_VECTORS - 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= boot_image_validator_pkg::ST_STRAP;
    end else begin
      case (state_r)
        boot_image_validator_pkg::ST_STRAP: begin
          // strap sampled on the first clock after release
          if (boot_mode_select) begin
            state_r <= boot_image_validator_pkg::ST_HDR_REQ;
          end else begin
            state_r <= boot_image_validator_pkg::ST_EXT_BOOT;
          end
        end
        boot_image_validator_pkg::ST_EXT_BOOT: begin
          state_r <= boot_image_validator_pkg::ST_EXT_BOOT;
        end
        boot_image_validator_pkg::ST_HDR_REQ: begin
          state_r <= boot_image_validator_pkg::ST_HDR_WAIT;
        end
        boot_image_validator_pkg::ST_HDR_WAIT: begin
          if (nvm_nak) begin
            state_r <= boot_image_validator_pkg::ST_NEXT_SRC;
          end else if (nvm_ack) begin
            if (!hdr_last) begin
              state_r <= boot_image_validator_pkg::ST_HDR_REQ;
            end else if (hdr_ok_r && vc.word_ok && blocks_r != 8'h00) begin
              state_r <= boot_image_validator_pkg::ST_COPY_REQ;
            end else if (hdr_ok_r && vc.word_ok) begin
              state_r <= boot_image_validator_pkg::ST_REMAP;
            end else begin
              state_r <= boot_image_validator_pkg::ST_NEXT_SRC;
            end
          end
        end
        boot_image_validator_pkg::ST_NEXT_SRC: begin
          // flash, then eeprom, then parallel memory when the bus exists
          if (src_r == boot_image_validator_pkg::SRC_SPI_FLASH ||
              (src_r == boot_image_validator_pkg::SRC_EEPROM && has_ext_bus)) begin
            state_r <= boot_image_validator_pkg::ST_HDR_REQ;
          end else begin
            state_r <= boot_image_validator_pkg::ST_UPLOAD;
          end
        end
        boot_image_validator_pkg::ST_COPY_REQ: begin
          state_r <= boot_image_validator_pkg::ST_COPY_WAIT;
        end
        boot_image_validator_pkg::ST_COPY_WAIT: begin
          if (nvm_nak) begin
            state_r <= boot_image_validator_pkg::ST_UPLOAD;
          end else if (nvm_ack && copy_last) begin
            state_r <= boot_image_validator_pkg::ST_REMAP;
          end else if (nvm_ack) begin
            state_r <= boot_image_validator_pkg::ST_COPY_REQ;
          end
        end
        boot_image_validator_pkg::ST_REMAP: begin
          state_r <= boot_image_validator_pkg::ST_RUN;
        end
        boot_image_validator_pkg::ST_RUN: begin
          state_r <= boot_image_validator_pkg::ST_RUN;
        end
        boot_image_validator_pkg::ST_UPLOAD: begin
          state_r <= boot_image_validator_pkg::ST_UPLOAD;
        end
        default: begin
          state_r <= boot_image_validator_pkg::ST_STRAP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and header scan

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_r <= boot_image_validator_pkg::SRC_SPI_FLASH;
    end else if (state_r == boot_image_validator_pkg::ST_NEXT_SRC) begin
      case (src_r)
        boot_image_validator_pkg::SRC_SPI_FLASH: src_r <= boot_image_validator_pkg::SRC_EEPROM;
        boot_image_validator_pkg::SRC_EEPROM: begin
          src_r <= has_ext_bus ? boot_image_validator_pkg::SRC_PARALLEL
                               : boot_image_validator_pkg::SRC_NONE;
        end
        default: src_r <= boot_image_validator_pkg::SRC_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_idx_r <= 3'h0;
      hdr_ok_r <= 1'b1;
    end else if (state_r == boot_image_validator_pkg::ST_NEXT_SRC) begin
      hdr_idx_r <= 3'h0;
      hdr_ok_r <= 1'b1;
    end else if (state_r == boot_image_validator_pkg::ST_HDR_WAIT && nvm_ack && !nvm_nak) begin
      hdr_idx_r <= hdr_idx_r + 3'h1;
      hdr_ok_r <= hdr_ok_r && vc.word_ok;
    end
  end

  // descriptor capture from the sixth word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blocks_r <= 8'h00;
      pages_exp_r <= 4'h0;
      page_size_r <= 15'h0000;
    end else if (state_r == boot_image_validator_pkg::ST_HDR_WAIT && nvm_ack && vc.is_desc) begin
      blocks_r <= vc.blocks;
      if (src_r == boot_image_validator_pkg::SRC_SPI_FLASH) begin
        pages_exp_r <= vc.pages_exp;
        page_size_r <= vc.page_size;
      end else begin
        pages_exp_r <= 4'h0;
        page_size_r <= 15'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      copy_idx_r <= 15'h0000;
    end else if (state_r == boot_image_validator_pkg::ST_NEXT_SRC) begin
      copy_idx_r <= 15'h0000;
    end else if (state_r == boot_image_validator_pkg::ST_COPY_WAIT && nvm_ack && !nvm_nak) begin
      copy_idx_r <= copy_idx_r + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory read port and sram writes

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_req <= 1'b0;
      nvm_src <= boot_image_validator_pkg::SRC_SPI_FLASH;
      nvm_addr <= 17'h00000;
    end else begin
      nvm_req <= state_r == boot_image_validator_pkg::ST_HDR_REQ ||
                 state_r == boot_image_validator_pkg::ST_COPY_REQ;
      nvm_src <= src_r;
      if (state_r == boot_image_validator_pkg::ST_HDR_REQ) begin
        nvm_addr <= {12'h000, hdr_idx_r, 2'b00};
      end else if (state_r == boot_image_validator_pkg::ST_COPY_REQ) begin
        nvm_addr <= {copy_idx_r, 2'b00};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sram_we <= 1'b0;
      sram_waddr <= 15'h0000;
      sram_wdata <= 32'h0000_0000;
    end else begin
      sram_we <= state_r == boot_image_validator_pkg::ST_COPY_WAIT && nvm_ack && !nvm_nak;
      if (state_r == boot_image_validator_pkg::ST_COPY_WAIT && nvm_ack) begin
        sram_waddr <= copy_idx_r;
        sram_wdata <= nvm_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot outcome

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remap <= 1'b0;
      cpu_start <= 1'b0;
      cpu_start_addr <= `BIV_RESET_VECTOR;
      ext_boot <= 1'b0;
      upload_mode <= 1'b0;
      boot_src <= boot_image_validator_pkg::SRC_NONE;
      image_blocks <= 8'h00;
      flash_pages_exp <= 4'h0;
      flash_pages <= 16'h0000;
      flash_page_size <= 15'h0000;
    end else begin
      cpu_start <= state_r == boot_image_validator_pkg::ST_REMAP;
      cpu_start_addr <= `BIV_RESET_VECTOR;
      if (state_r == boot_image_validator_pkg::ST_REMAP) begin
        remap <= 1'b1;
        boot_src <= src_r;
        image_blocks <= blocks_r;
        flash_pages_exp <= pages_exp_r;
        flash_pages <= 16'h0001 << pages_exp_r;
        flash_page_size <= page_size_r;
      end
      if (state_r == boot_image_validator_pkg::ST_EXT_BOOT) begin
        ext_boot <= 1'b1;
      end
      if (state_r == boot_image_validator_pkg::ST_UPLOAD) begin
        upload_mode <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode and rom descriptor

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_sel <= 1'b0;
      sram_sel <= 1'b0;
    end else begin
      if ((cpu_addr & `BIV_REGION_MASK) == `BIV_ROM_ALIAS_BASE) begin
        rom_sel <= 1'b1;
        sram_sel <= 1'b0;
      end else if ((cpu_addr & `BIV_REGION_MASK) == `BIV_RESET_VECTOR) begin
        rom_sel <= !remap;
        sram_sel <= remap;
      end else begin
        rom_sel <= 1'b0;
        sram_sel <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_desc_data <= 32'h0000_0000;
    end else begin
      case (rom_desc_idx)
        2'h0: rom_desc_data <= `BIV_CHIP_ID;
        2'h1: rom_desc_data <= `BIV_ENTRY_READ_NVM;
        2'h2: rom_desc_data <= `BIV_ENTRY_COPY;
        default: rom_desc_data <= `BIV_ENTRY_UPLOAD;
      endcase
    end
  end

endmodule // boot_image_validator

/* tb/boot_image_validator_properties.sv */
// concurrent checks on the boot image validator ports
`timescale 1ns/1ps
`include "boot_image_validator_defs.svh"
module boot_image_validator_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // memory and copy
  input wire logic nvm_req,
  input wire logic nvm_ack,
  input wire logic [31:0] nvm_rdata,
  input wire logic sram_we,
  input wire logic [31:0] sram_wdata,
  // decode
  input wire logic [31:0] cpu_addr,
  input wire logic rom_sel,
  input wire logic sram_sel,
  input wire logic [1:0] rom_desc_idx,
  input wire logic [31:0] rom_desc_data,
  // outcome
  input wire logic remap,
  input wire logic cpu_start,
  input wire logic [31:0] cpu_start_addr,
  input wire logic ext_boot,
  input wire logic upload_mode,
  input wire boot_image_validator_pkg::nvm_src_t boot_src,
  input wire logic [3:0] flash_pages_exp,
  input wire logic [15:0] flash_pages,
  input wire logic [14:0] flash_page_size
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_start;
    cpu_start |-> remap && !$past(remap) && cpu_start_addr == 32'h0000_0000;
  endproperty
  a_start: assert property (p_start) else $error("start without fresh remap");
  property p_alias;
    cpu_addr[31:20] == 12'h001 |=> rom_sel && !sram_sel;
  endproperty
  a_alias: assert property (p_alias) else $error("alias base not rom");
  property p_low_rom;
    (!remap && cpu_addr[31:20] == 12'h000) ##1 !remap |-> rom_sel && !sram_sel;
  endproperty
  a_low_rom: assert property (p_low_rom) else $error("low base not rom");
  property p_low_sram;
    remap && cpu_addr[31:20] == 12'h000 |=> sram_sel && !rom_sel;
  endproperty
  a_low_sram: assert property (p_low_sram) else $error("low base not sram");
  property p_copy;
    sram_we |-> $past(nvm_ack) && sram_wdata == $past(nvm_rdata);
  endproperty
  a_copy: assert property (p_copy) else $error("sram write not from read");
  property p_geom;
    remap && boot_src != boot_image_validator_pkg::SRC_SPI_FLASH
      |-> flash_pages_exp == 4'h0 && flash_page_size == 15'h0000;
  endproperty
  a_geom: assert property (p_geom) else $error("geometry used off flash");
  property p_pages;
    remap && boot_src == boot_image_validator_pkg::SRC_SPI_FLASH
      |-> flash_pages == (16'h0001 << flash_pages_exp);
  endproperty
  a_pages: assert property (p_pages) else $error("page count wrong");
  property p_strap;
    ext_boot |-> !nvm_req && !remap && !upload_mode;
  endproperty
  a_strap: assert property (p_strap) else $error("loader ran strapped off");
  property p_upload;
    upload_mode |=> upload_mode && !remap && !nvm_req;
  endproperty
  a_upload: assert property (p_upload) else $error("upload not final");
  property p_desc;
    rom_desc_idx == 2'h0 |=> rom_desc_data == `BIV_CHIP_ID;
  endproperty
  a_desc: assert property (p_desc) else $error("chip id wrong");
endmodule // boot_image_validator_properties

/* tb/nvm_model.sv */
// word-read model of the three boot memories
`timescale 1ns/1ps
module nvm_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic nvm_req,
  input wire boot_image_validator_pkg::nvm_src_t nvm_src,
  input wire logic [16:0] nvm_addr,
  output logic nvm_ack,
  output logic nvm_nak,
  output logic [31:0] nvm_rdata
);
  logic [31:0] hdr [3][8];
  logic present [3];
  int lat = 1;
  initial begin
    nvm_ack = 1'b0;
    nvm_nak = 1'b0;
    nvm_rdata = 32'h0000_0000;
  end
  always begin
    @(posedge clk);
    if (nvm_req) begin
      repeat (lat - 1) @(posedge clk);
      // absent device answers with no acknowledge
      if (!present[nvm_src]) nvm_nak <= 1'b1;
      else nvm_ack <= 1'b1;
      if (nvm_addr < 17'h00020) nvm_rdata <= hdr[nvm_src][nvm_addr[4:2]];
      else nvm_rdata <= 32'hC3C3_0000 ^ {15'h0000, nvm_addr};
      @(posedge clk);
      nvm_ack <= 1'b0;
      nvm_nak <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
    end
  end
endmodule // nvm_model

/* tb/boot_image_validator_test.sv */
// self-checking bench of the boot image validator
`timescale 1ns/1ps
`include "boot_image_validator_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module boot_image_validator_test;
  logic clk, arst_n, boot_mode_select, has_ext_bus, nvm_req, nvm_ack, nvm_nak;
  logic sram_we, rom_sel, sram_sel, remap, cpu_start, ext_boot, upload_mode;
  logic [16:0] nvm_addr;
  logic [31:0] nvm_rdata, sram_wdata, cpu_addr, rom_desc_data, cpu_start_addr;
  logic [14:0] sram_waddr, flash_page_size;
  logic [1:0] rom_desc_idx;
  logic [7:0] image_blocks;
  logic [3:0] flash_pages_exp;
  logic [15:0] flash_pages;
  boot_image_validator_pkg::nvm_src_t nvm_src, boot_src;
  logic [31:0] sram [32768];
  logic [31:0] ids [4] = '{`BIV_CHIP_ID, `BIV_ENTRY_READ_NVM, `BIV_ENTRY_COPY, `BIV_ENTRY_UPLOAD};
  boot_image_validator_pkg::nvm_src_t order [$];
  int n_we, n_start, cyc, n_errors, checks, i;

  boot_image_validator dut (.clk, .arst_n, .boot_mode_select, .has_ext_bus, .nvm_req, .nvm_src,
    .nvm_addr, .nvm_ack, .nvm_nak, .nvm_rdata, .sram_we, .sram_waddr, .sram_wdata, .cpu_addr,
    .rom_sel, .sram_sel, .rom_desc_idx, .rom_desc_data, .remap, .cpu_start, .cpu_start_addr,
    .ext_boot, .upload_mode, .boot_src, .image_blocks, .flash_pages_exp, .flash_pages,
    .flash_page_size);
  nvm_model mem (.clk, .nvm_req, .nvm_src, .nvm_addr, .nvm_ack, .nvm_nak, .nvm_rdata);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (sram_we) sram[sram_waddr] <= sram_wdata;
    if (sram_we) n_we++;
    if (cpu_start) n_start++;
    if (nvm_req && (order.size() == 0 || order[$] != nvm_src)) order.push_back(nvm_src);
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic load(input int s, input logic [31:0] desc);
    mem.hdr[s] = '{32'hEA00_000B, 32'hE59F_F014, 32'hE59F_F014, 32'hE59F_F014,
      32'hE59F_F014, desc, 32'hE51F_FF20, 32'hE51F_FF20};
    mem.present[s] = 1'b1;
  endtask
  task automatic run(input logic strap, input logic ext);
    int k;
    @(negedge clk);
    arst_n = 1'b0;
    boot_mode_select = strap;
    has_ext_bus = ext;
    order.delete();
    n_we = 0;
    n_start = 0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    for (k = 0; k < 20000 && !(remap || upload_mode || ext_boot); k++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  task automatic dec(input logic [31:0] a, input logic [1:0] sel);
    cpu_addr = a;
    @(negedge clk);
    `CHK({rom_sel, sram_sel}, sel)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    boot_mode_select = 1'b0;
    has_ext_bus = 1'b0;
    cpu_addr = 32'h0000_0000;
    rom_desc_idx = 2'h0;
    for (i = 0; i < 3; i++) mem.present[i] = 1'b0;
    run(1'b0, 1'b0);
    `CHK(ext_boot, 1'b1)
    `CHK(order.size() == 0, 1'b1)
    dec(32'h0000_0000, 2'h2);
    dec(32'h0010_0000, 2'h2);
    dec(32'h0020_0000, 2'h0);
    for (i = 0; i < 4; i++) begin
      rom_desc_idx = i[1:0];
      @(negedge clk);
      `CHK(rom_desc_data, ids[i])
    end
    $display("test strap_off done");
    load(0, 32'h0841_A017);
    run(1'b1, 1'b0);
    `CHK(remap, 1'b1)
    `CHK(n_start == 1, 1'b1)
    `CHK(cpu_start_addr, 32'h0000_0000)
    `CHK(boot_src, boot_image_validator_pkg::SRC_SPI_FLASH)
    `CHK(image_blocks, 8'h17)
    `CHK(flash_pages, 16'h2000)
    `CHK(flash_page_size, 15'h0420)
    `CHK(n_we == 23 * 128, 1'b1)
    `CHK(sram[5], 32'h0841_A017)
    `CHK(sram[23 * 128 - 1], 32'hC3C3_2DFC)
    dec(32'h0000_0000, 2'h1);
    dec(32'h0010_0000, 2'h2);
    $display("test flash_boot done");
    mem.hdr[0][2] = 32'hD59F_F014;
    load(1, 32'h0841_1F02);
    mem.lat = 2;
    run(1'b1, 1'b0);
    `CHK(boot_src, boot_image_validator_pkg::SRC_EEPROM)
    `CHK(image_blocks, 8'h02)
    `CHK({flash_pages_exp, flash_page_size}, 19'h00000)
    `CHK(n_we == 256, 1'b1)
    $display("test eeprom_boot done");
    mem.present[0] = 1'b0;
    mem.present[1] = 1'b0;
    load(2, 32'hFFFF_FF00);
    mem.hdr[2][7] = 32'hEAFF_FFFF;
    mem.lat = 1;
    run(1'b1, 1'b1);
    `CHK(order.size() == 3 && order[2] == boot_image_validator_pkg::SRC_PARALLEL, 1'b1)
    `CHK(boot_src, boot_image_validator_pkg::SRC_PARALLEL)
    `CHK(remap, 1'b1)
    `CHK(n_we == 0, 1'b1)
    `CHK(flash_page_size, 15'h0000)
    $display("test parallel_boot done");
    load(0, 32'h0000_0001);
    mem.hdr[0][3] = 32'hE49F_F014;
    load(1, 32'h0000_0001);
    mem.hdr[1][4] = 32'hE59E_F014;
    mem.hdr[2][0] = 32'hEB00_000B;
    run(1'b1, 1'b1);
    `CHK(upload_mode, 1'b1)
    `CHK(remap, 1'b0)
    `CHK(order.size() == 3, 1'b1)
    mem.present[0] = 1'b0;
    mem.present[1] = 1'b0;
    load(2, 32'h0000_0001);
    run(1'b1, 1'b0);
    `CHK(upload_mode, 1'b1)
    `CHK(order.size() == 2, 1'b1)
    $display("test upload done");
    results();
  end
endmodule // boot_image_validator_test

bind boot_image_validator boot_image_validator_properties chk (.clk, .arst_n, .nvm_req, .nvm_ack,
  .nvm_rdata, .sram_we, .sram_wdata, .cpu_addr, .rom_sel, .sram_sel, .rom_desc_idx,
  .rom_desc_data, .remap, .cpu_start, .cpu_start_addr, .ext_boot, .upload_mode, .boot_src,
  .flash_pages_exp, .flash_pages, .flash_page_size);
